// >>> usb_dev_irq_enable_frame_ep_reset_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usb_dev_irq_enable_frame_ep_reset_tb;
   import usbdie_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } usbdie_row_t;
   logic mclk, rstn, avsRead, avsWrite, avsWaitRequest, usbBusReset;
   logic usbIrq, sofFlag, sofValid, sofCrcBad, clkEn;
   logic [7:0] avsAddress;
   logic [10:0] sofNumber;
   logic [31:0] avsWriteData, avsReadData, eventFlags, flagStatus, rd;
   logic [6:0] endpointActive, endpointRegReset, endpointFifoReset;
   int errors, num_checks, cycles;
   // Strobe write, then expected enable readback
   usbdie_row_t rows [7] = '{
      '{OFS_EN_SET, 32'hFFFF_FFFF, 32'h7E07_F07D},
      '{OFS_EN_CLR, 32'h0000_1040, 32'h7E07_E03D},
      '{OFS_EN_SET, 32'h0000_0000, 32'h7E07_E03D},
      '{OFS_EN_CLR, 32'h0000_0000, 32'h7E07_E03D},
      '{OFS_EN_SET, 32'h0200_1000, 32'h7E07_F03D},
      '{OFS_EN_CLR, 32'hFFFF_FFFF, 32'h0000_0000},
      '{OFS_EN_SET, 32'h0000_0040, 32'h0000_0040}};

   usbdie_top i_dut (.mclk, .rstn, .clkEn, .avsAddress, .avsRead,
      .avsWrite, .avsWriteData, .avsReadData, .avsWaitRequest, .usbBusReset,
      .sofValid, .sofCrcBad, .sofNumber, .eventFlags, .flagStatus, .usbIrq,
      .endpointActive, .endpointRegReset, .endpointFifoReset, .sofFlag);
   usbdie_host_model i_host (.mclk, .sofValid, .sofCrcBad, .sofNumber);

   // Clock, 20 ns period
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Hang guard, far above the roughly 150 cycles used
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Request held until waitrequest is sampled low
   task automatic busOp(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge mclk);
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= wr;
      avsRead <= ~wr;
      do @(posedge mclk); while (avsWaitRequest !== 1'b0);
      rd = avsReadData;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
         input string nm);
      busOp(1'b0, a, 32'h0000_0000);
      check(nm, rd, e);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      rstn = 1'b0;
      clkEn = 1'b1;
      avsAddress = 8'h00;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsWriteData = 32'h0000_0000;
      usbBusReset = 1'b0;
      eventFlags = 32'h0000_0000;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      rdChk(OFS_ENABLE, EN_RESET, "enable");
      rdChk(OFS_EP_RST, EP_RST_RESET, "epReset");
      rdChk(OFS_FRAME_NUMBER, FRAME_NUMBER_RESET, "frame");
      check("regReset", {25'h0, endpointRegReset}, 32'h7F);
      $display("test reset done");
      foreach (rows[i]) begin
         busOp(1'b1, rows[i].a, rows[i].d);
         rdChk(rows[i].a, 32'h0, "strobeRead");
         rdChk(OFS_ENABLE, rows[i].e, "enable");
      end
      $display("test strobes done");
      i_host.sendSof(11'h7FF, 1'b0);
      // Pulse stands in the cycle after the token was seen
      @(posedge mclk);
      check("sofFlag", {31'h0, sofFlag}, 32'h1);
      rdChk(OFS_FRAME_NUMBER, 32'h0000_3FF8, "frame");
      i_host.sendSof(11'h123, 1'b1);
      rdChk(OFS_FRAME_NUMBER, 32'h0000_8918, "frameCrc");
      check("sofStatus", {31'h0, flagStatus[EN_SOF_POS]}, 32'h1);
      $display("test frame done");
      // Endpoint 0 event while only upstream resume is enabled
      @(posedge mclk);
      eventFlags <= 32'h0000_1000;
      @(posedge mclk);
      eventFlags <= 32'h0000_0000;
      rdChk(OFS_FLAGS, 32'h0000_1004, "flags");
      check("irqMasked", {31'h0, usbIrq}, 32'h0);
      busOp(1'b1, OFS_EN_SET, 32'h0000_1000);
      rdChk(OFS_ENABLE, 32'h0000_1040, "enable");
      check("irqOn", {31'h0, usbIrq}, 32'h1);
      busOp(1'b1, OFS_EN_CLR, 32'h0000_1000);
      rdChk(OFS_ENABLE, 32'h0000_0040, "enable");
      check("irqOff", {31'h0, usbIrq}, 32'h0);
      $display("test irq done");
      busOp(1'b1, OFS_EP_RST, 32'h007F_007F);
      rdChk(OFS_EP_RST, 32'h007F_007F, "epReset");
      check("active", {25'h0, endpointActive}, 32'h7F);
      check("fifoReset", {25'h0, endpointFifoReset}, 32'h7F);
      check("regReset", {25'h0, endpointRegReset}, 32'h7F);
      busOp(1'b1, OFS_EP_RST, 32'h0001_007E);
      rdChk(OFS_EP_RST, 32'h0001_007E, "epReset");
      check("active", {25'h0, endpointActive}, 32'h7E);
      check("regReset", {25'h0, endpointRegReset}, 32'h01);
      @(posedge mclk);
      usbBusReset <= 1'b1;
      @(posedge mclk);
      usbBusReset <= 1'b0;
      rdChk(OFS_EP_RST, 32'h0000_007E, "epReset");
      rdChk(OFS_FRAME_NUMBER, 32'h0000_0000, "frame");
      check("fifoReset", {25'h0, endpointFifoReset}, 32'h0);
      rdChk(8'h3C, 32'h0000_0000, "unmapped");
      $display("test endpoints done");
      // Frozen clock enable: an SOF must leave the frame number alone
      @(posedge mclk);
      clkEn <= 1'b0;
      i_host.sendSof(11'h055, 1'b1);
      @(posedge mclk);
      clkEn <= 1'b1;
      rdChk(OFS_FRAME_NUMBER, FRAME_NUMBER_RESET, "frozenFrame");
      $display("test clock enable done");
      // Reset in mid-run brings enables and endpoints back to reset state
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      rdChk(OFS_ENABLE, EN_RESET, "enable");
      rdChk(OFS_EP_RST, EP_RST_RESET, "epReset");
      check("regReset", {25'h0, endpointRegReset}, 32'h7F);
      check("irqReset", {31'h0, usbIrq}, 32'h0);
      $display("test mid-run reset done");
      stop_test();
   end
endmodule // usb_dev_irq_enable_frame_ep_reset_tb
`default_nettype wire

// >>> usbdie_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module usbdie_host_model (
   input wire logic mclk,
   output logic sofValid,
   output logic sofCrcBad,
   output logic [10:0] sofNumber
);
   // Idle link: no token pending
   initial begin
      sofValid = 1'b0;
      sofCrcBad = 1'b0;
      sofNumber = 11'h000;
   end
   // One decoded SOF token, CRC good or corrupted
   task automatic sendSof(input logic [10:0] num, input logic bad);
      @(posedge mclk);
      sofValid <= 1'b1;
      sofCrcBad <= bad;
      sofNumber <= num;
      @(posedge mclk);
      sofValid <= 1'b0;
      // Stale fields scrambled so nothing leans on them
      sofCrcBad <= ~bad;
      sofNumber <= ~num;
   endtask
endmodule // usbdie_host_model
`default_nettype wire

// >>> usbdie_pkg.sv
package usbdie_pkg;
   // Register offsets (byte addresses, word aligned)
   localparam logic [7:0] OFS_FLAGS = 8'h04;
   localparam logic [7:0] OFS_ENABLE = 8'h10;
   localparam logic [7:0] OFS_EN_CLR = 8'h14;
   localparam logic [7:0] OFS_EN_SET = 8'h18;
   localparam logic [7:0] OFS_EP_RST = 8'h1C;
   localparam logic [7:0] OFS_FRAME_NUMBER = 8'h20;
   // Enable register layout
   localparam int EN_SUSP_POS = 0;
   localparam int EN_SOF_POS = 2;
   localparam int EN_EORST_POS = 3;
   localparam int EN_WAKE_POS = 4;
   localparam int EN_EORSM_POS = 5;
   localparam int EN_UPRSM_POS = 6;
   localparam int EN_EP_POS = 12;
   localparam int EN_DMA_POS = 25;
   localparam logic [31:0] EN_WMASK = 32'h7E07_F07D;
   // Endpoint enable/reset layout
   localparam int EP_EN_POS = 0;
   localparam int EP_RST_POS = 16;
   localparam logic [31:0] EP_RST_RESET = 32'h0000_0000;
   // Frame number layout
   localparam int FRAME_NUMBER_POS = 3;
   localparam int FRAME_NUMBER_CRC_ERROR_POS = 15;
   localparam logic [31:0] FRAME_NUMBER_RESET = 32'h0000_0000;
   localparam logic [31:0] EN_RESET = 32'h0000_0000;
   localparam int NUM_EP = 7;
   localparam int NUM_DMA = 6;
   localparam int FRAME_NUMBER_W = 11;

   // Avalon-MM request bundle
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } usbdie_avreq_t;

   // Received start-of-frame event
   typedef struct packed {
      logic valid;
      logic crcBad;
      logic [10:0] number;
   } usbdie_sof_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } usbdie_bus_t;
endpackage

// >>> usbdie_top.sv
// Functional notes
// - Upstream resume enable set by its set strobe, cleared by its clear strobe.
// - Endpoint 0..6 interrupt enables each have own set and clear strobes.
// - DMA channel 1..6 interrupt enables each have own set and clear strobes.
// - Enable-clear register clears enables written with one, others unchanged.
// - Enable-set register sets enables written with one, others unchanged.
// - Zero writes to strobes do nothing; strobe registers read all zero.
// - Capture 11-bit frame number of each received SOF, read-only field.
// - Frame number updated even when the SOF CRC check fails.
// - CRC error flag updated in same cycle as start-of-frame flag.
// - USB bus reset clears frame number, CRC error flag, FIFO resets.
// - Writing one to an endpoint enable bit enables that endpoint.
// - Cleared enable idles endpoint, resets its regs except configuration.
// - FIFO reset bit high resets FIFO and regs, configuration kept.
// - FIFO reset spares the data toggle; toggle reset by separate strobe.
// - During FIFO reset endpoint stays configured and enabled.
// - Each flag raises the interrupt only while its enable is one.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module usbdie_top
   import usbdie_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic [7:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   input wire logic usbBusReset,
   input wire logic sofValid,
   input wire logic sofCrcBad,
   input wire logic [10:0] sofNumber,
   input wire logic [31:0] eventFlags,
   output logic [31:0] flagStatus,
   output logic usbIrq,
   output logic [6:0] endpointActive,
   output logic [6:0] endpointRegReset,
   output logic [6:0] endpointFifoReset,
   output logic sofFlag
);
   import usbdie_pkg::*;

   usbdie_avreq_t req;
   usbdie_sof_t sof;
   usbdie_bus_t busReg;
   logic [31:0] enableReg;
   logic [31:0] epRstReg;
   logic [31:0] fnumReg;
   logic [31:0] flagReg;
   logic access;
   logic wrHit;
   logic [31:0] enableNext;

   // Bundle the bus and SOF inputs
   assign req = '{avsAddress, avsRead, avsWrite, avsWriteData};
   assign sof = '{sofValid, sofCrcBad, sofNumber};

   // One wait cycle: request is accepted on the second edge it is held
   assign access = (req.read || req.write) && busReg == BUS_ACK;
   assign wrHit = req.write && busReg == BUS_ACK;

   // Bus acknowledge sequencer
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         busReg <= BUS_IDLE;
         avsWaitRequest <= 1'b1;
      end else if (clkEn) begin
         case (busReg)
            BUS_IDLE: begin
               if (req.read || req.write) begin
                  busReg <= BUS_ACK;
                  avsWaitRequest <= 1'b0;
               end
            end
            BUS_ACK: begin
               busReg <= BUS_IDLE;
               avsWaitRequest <= 1'b1;
            end
            default: begin
               busReg <= BUS_IDLE;
               avsWaitRequest <= 1'b1;
            end
         endcase
      end
   end

   // Wait request drops for a single cycle per accepted request
   chk_wait_once: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && !avsWaitRequest |=> avsWaitRequest)
      else $error("waitrequest low too long");

   // Without a request the bus stays in wait, no phantom acknowledge
   chk_idle_wait: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && busReg == BUS_IDLE && !req.read && !req.write |=>
      avsWaitRequest)
      else $error("acknowledge without request");

   // An idle request is answered on the very next edge
   chk_req_ack: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && busReg == BUS_IDLE && (req.read || req.write) |=>
      !avsWaitRequest)
      else $error("request not acknowledged");

   // Execution only inside the acknowledge window
   chk_ack_window: assert property (@(posedge mclk) disable iff (!rstn)
      access |-> !avsWaitRequest)
      else $error("access outside ack cycle");

   // Read data is registered when the request is seen, stands at ack edge
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         avsReadData <= 32'h0000_0000;
      end else if (clkEn) begin
         if (busReg == BUS_IDLE && req.read) begin
            case (req.address)
               OFS_FLAGS: avsReadData <= flagReg;
               OFS_ENABLE: avsReadData <= enableReg;
               OFS_EP_RST: avsReadData <= epRstReg;
               OFS_FRAME_NUMBER: avsReadData <= fnumReg;
               // Strobe registers and unmapped words read as zero
               default: avsReadData <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Read data stands until the next read is taken
   chk_read_hold: assert property (@(posedge mclk) disable iff (!rstn)
      !(clkEn && busReg == BUS_IDLE && req.read) |=> $stable(avsReadData))
      else $error("read data changed unasked");

   // Enable update: clear first, then set, zero bits leave enables alone
   always_comb begin
      enableNext = enableReg;
      if (wrHit && req.address == OFS_EN_CLR) begin
         enableNext = enableReg & ~(req.writedata & EN_WMASK);
      end
      if (wrHit && req.address == OFS_EN_SET) begin
         enableNext = enableReg | (req.writedata & EN_WMASK);
      end
   end

   // Global interrupt enables
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         enableReg <= EN_RESET;
      end else if (clkEn) begin
         enableReg <= enableNext;
      end
   end

   // Reserved enable bits can never be set
   chk_en_mask: assert property (@(posedge mclk) disable iff (!rstn)
      (enableReg & ~EN_WMASK) == 32'h0)
      else $error("reserved enable bit set");

   // Enables move only on a strobe write
   chk_en_hold: assert property (@(posedge mclk) disable iff (!rstn)
      !(clkEn && wrHit && (req.address == OFS_EN_SET ||
      req.address == OFS_EN_CLR)) |=> $stable(enableReg))
      else $error("enable changed without strobe");

   // A strobe word of all zeros changes nothing
   chk_zero_strobe: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && wrHit && req.writedata == 32'h0 &&
      (req.address == OFS_EN_SET || req.address == OFS_EN_CLR) |=>
      $stable(enableReg))
      else $error("zero strobe changed enables");

   // Endpoint enable and FIFO reset; bus reset wins over software write
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         epRstReg <= EP_RST_RESET;
      end else if (clkEn) begin
         if (wrHit && req.address == OFS_EP_RST) begin
            epRstReg[EP_EN_POS +: NUM_EP] <=
               req.writedata[EP_EN_POS +: NUM_EP];
            epRstReg[EP_RST_POS +: NUM_EP] <=
               req.writedata[EP_RST_POS +: NUM_EP];
         end
         if (usbBusReset) begin
            epRstReg[EP_RST_POS +: NUM_EP] <= 7'h00;
         end
      end
   end

   // Enables survive FIFO and bus resets, only writes move them
   chk_active_hold: assert property (@(posedge mclk) disable iff (!rstn)
      !(clkEn && wrHit && req.address == OFS_EP_RST) |=>
      $stable(endpointActive))
      else $error("endpoint enable moved");

   // Frame number capture, taken even on bad CRC
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         fnumReg <= FRAME_NUMBER_RESET;
         sofFlag <= 1'b0;
      end else if (clkEn) begin
         sofFlag <= 1'b0;
         if (usbBusReset) begin
            fnumReg <= FRAME_NUMBER_RESET;
         end else if (sof.valid) begin
            fnumReg[FRAME_NUMBER_POS +: FRAME_NUMBER_W] <= sof.number;
            fnumReg[FRAME_NUMBER_CRC_ERROR_POS] <= sof.crcBad;
            sofFlag <= 1'b1;
         end
      end
   end

   // Frame number only moves on an SOF or a bus reset
   chk_frame_number_hold: assert property (@(posedge mclk) disable iff (!rstn)
      !(clkEn && (sof.valid || usbBusReset)) |=> $stable(fnumReg))
      else $error("frame number moved");

   // Start-of-frame pulse never appears without a received SOF
   chk_sof_quiet: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && !(sof.valid && !usbBusReset) |=> !sofFlag)
      else $error("stray start-of-frame pulse");

   // Sticky flags: hardware set beats a same-cycle software clear
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         flagReg <= 32'h0000_0000;
      end else if (clkEn) begin
         if (wrHit && req.address == OFS_FLAGS) begin
            flagReg <= (flagReg & ~req.writedata) | eventFlags
               | (sof.valid ? (32'h1 << EN_SOF_POS) : 32'h0);
         end else begin
            flagReg <= flagReg | eventFlags
               | (sof.valid ? (32'h1 << EN_SOF_POS) : 32'h0);
         end
      end
   end

   // Flags only fall on a software clear write
   chk_flag_sticky: assert property (@(posedge mclk) disable iff (!rstn)
      !(clkEn && wrHit && req.address == OFS_FLAGS) |=>
      ($past(flagReg) & ~flagReg) == 32'h0)
      else $error("sticky flag lost");

   // Endpoint controls; configuration fields sit outside and are not touched
   genvar ep;
   generate
      for (ep = 0; ep < NUM_EP; ep++) begin : gEp
         always_ff @(posedge mclk) begin
            if (!rstn) begin
               endpointActive[ep] <= 1'b0;
               endpointRegReset[ep] <= 1'b1;
               endpointFifoReset[ep] <= 1'b0;
            end else if (clkEn) begin
               // Disabled endpoint idles and its regs held reset
               endpointActive[ep] <= epNextEn(ep);
               endpointRegReset[ep] <= !epNextEn(ep)
                  || epNextRst(ep);
               // Toggle is not on this line, it keeps its own reset
               endpointFifoReset[ep] <= epNextRst(ep);
            end
         end
      end
   endgenerate

   // Output copies track the register bits they come from
   chk_fifo_line: assert property (@(posedge mclk) disable iff (!rstn)
      endpointFifoReset == epRstReg[EP_RST_POS +: NUM_EP])
      else $error("fifo reset line off");
   chk_reg_reset: assert property (@(posedge mclk) disable iff (!rstn)
      endpointRegReset == (~epRstReg[EP_EN_POS +: NUM_EP] |
      epRstReg[EP_RST_POS +: NUM_EP]))
      else $error("register reset line off");

   // A software write lands on the FIFO reset lines unless bus reset wins
   chk_fifo_write: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && wrHit && req.address == OFS_EP_RST && !usbBusReset |=>
      endpointFifoReset == $past(req.writedata[EP_RST_POS +: NUM_EP]))
      else $error("fifo reset write lost");

   // Next-cycle view of the endpoint enable and reset bits
   function automatic logic epNextEn(input int idx);
      epNextEn = (wrHit && req.address == OFS_EP_RST)
         ? req.writedata[EP_EN_POS + idx] : epRstReg[EP_EN_POS + idx];
   endfunction

   function automatic logic epNextRst(input int idx);
      if (usbBusReset) begin
         epNextRst = 1'b0;
      end else if (wrHit && req.address == OFS_EP_RST) begin
         epNextRst = req.writedata[EP_RST_POS + idx];
      end else begin
         epNextRst = epRstReg[EP_RST_POS + idx];
      end
   endfunction

   // Interrupt and status outputs registered
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         usbIrq <= 1'b0;
         flagStatus <= 32'h0000_0000;
      end else if (clkEn) begin
         usbIrq <= |(flagReg & enableReg);
         flagStatus <= flagReg;
      end
   end

   // Interrupt follows enabled flags one edge later, both ways
   chk_irq_quiet: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && (flagReg & enableReg) == 32'h0 |=> !usbIrq)
      else $error("irq with no enabled flag");
   chk_irq_raise: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && (flagReg & enableReg) != 32'h0 |=> usbIrq)
      else $error("enabled flag gave no irq");

   // Checks
   chk_irq_gate: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && $past(clkEn) && usbIrq |-> |($past(flagReg & enableReg)))
      else $error("irq without enabled flag");
   chk_set_strobe: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && wrHit && req.address == OFS_EN_SET |=>
      (enableReg & $past(req.writedata) & EN_WMASK) ==
      ($past(req.writedata) & EN_WMASK))
      else $error("set strobe missed");
   chk_clr_strobe: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && wrHit && req.address == OFS_EN_CLR |=>
      (enableReg & $past(req.writedata) & EN_WMASK) == 32'h0)
      else $error("clear strobe missed");
   chk_frame_number_cap: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && sof.valid && !usbBusReset |=>
      !$past(clkEn) || fnumReg[FRAME_NUMBER_POS +: FRAME_NUMBER_W] == $past(sof.number))
      else $error("frame number not captured");
   chk_crc_flag: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && sof.valid && !usbBusReset |=>
      fnumReg[FRAME_NUMBER_CRC_ERROR_POS] == $past(sof.crcBad) && sofFlag)
      else $error("crc flag not with sof");
   chk_bus_reset: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && usbBusReset |=>
      fnumReg == 32'h0 && epRstReg[EP_RST_POS +: NUM_EP] == 7'h00)
      else $error("bus reset left state");
   chk_strobe_read: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && busReg == BUS_IDLE && req.read &&
      (req.address == OFS_EN_SET || req.address == OFS_EN_CLR) |=>
      avsReadData == 32'h0)
      else $error("strobe read nonzero");
   chk_ep_enable: assert property (@(posedge mclk) disable iff (!rstn)
      clkEn && wrHit && req.address == OFS_EP_RST |=>
      endpointActive == $past(req.writedata[6:0]))
      else $error("endpoint enable wrong");
endmodule // usbdie_top
`default_nettype wire
